// ### note_env_defines.svh
// constants for the note envelope generator: offsets, fields, reset values
`ifndef NOTE_ENV_DEFINES_SVH
`define NOTE_ENV_DEFINES_SVH

`define AXI_ADDR_W 12
`define CH_IDX_W 4
`define CH_SHIFT 6
`define CH_MAX 16

`define OFS_ATTACK 6'h00
`define OFS_DECAY 6'h04
`define OFS_SUSTAIN 6'h08
`define OFS_RELEASE 6'h0C
`define OFS_VOLUME 6'h10
`define OFS_GAP 6'h14
`define OFS_LOUD 6'h18
`define OFS_RATE 6'h1C
`define OFS_PHASE 6'h20

`define LOUD_CUR_LSB 0
`define LOUD_DES_LSB 16
`define RATE_DEC_LSB 0
`define RATE_SUS_LSB 16
`define PHASE_REM_LSB 0
`define PHASE_PH_LSB 16

`define RST_ATTACK 16'h2000
`define RST_DECAY 16'h0000
`define RST_SUSTAIN 16'h0000
`define RST_RELEASE 16'h0000
`define RST_VOLUME 16'h0000
`define RST_GAP 16'hFFFF
`define GAP_OFF 16'hFFFF

`define VOL_SHIFT_1CH 12
`define VOL_SHIFT_16CH 8

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RESP_DECERR 2'b11

`endif

// ### note_env_pkg.sv
// types shared by the note envelope generator
`default_nettype none
package note_env_pkg;

  typedef enum logic [1:0] {
    PH_QUIET = 2'b00,
    PH_NOTE = 2'b01,
    PH_RELEASE = 2'b11,
    PH_REST = 2'b10
  } phase_e;

  typedef struct packed {
    logic [15:0] attack;
    logic [15:0] decay;
    logic [15:0] sustain;
    logic [15:0] release_rate;
    logic [15:0] volume;
    logic [15:0] gap;
  } settings_s;

  typedef struct packed {
    logic [15:0] cur;
    logic [15:0] desired;
    logic [15:0] cur_sus;
    logic [15:0] cur_dec;
    logic [15:0] remaining;
    phase_e phase;
  } chan_s;

  typedef struct packed {
    logic aw_pend;
    logic [11:0] aw_addr;
    logic w_pend;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_s;

endpackage
`default_nettype wire

// ### env_channel.sv
// one channel of loudness stepping, note and release handling
`timescale 1ns/1ps
`default_nettype none
`include "note_env_defines.svh"
module env_channel
  import note_env_pkg::*;
#(
  parameter int VOL_SHIFT = `VOL_SHIFT_1CH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic note_start,
  input wire logic rest_hit,
  input wire logic [15:0] note_len,
  input wire logic [15:0] set_attack,
  input wire logic [15:0] set_decay,
  input wire logic [15:0] set_sustain,
  input wire logic [15:0] set_release,
  input wire logic [15:0] set_volume,
  input wire logic [15:0] set_gap,
  output logic [15:0] cur_loud,
  output logic [15:0] desired_loud,
  output logic [15:0] cur_sustain,
  output logic [15:0] cur_decay,
  output logic [15:0] remaining,
  output phase_e phase,
  output logic [15-VOL_SHIFT:0] card_volume
);

  chan_s state_reg;
  chan_s state_next;
  logic [15:0] diff;
  logic gap_hit;

  always_comb begin
    state_next = state_reg;
    diff = 16'h0000;
    gap_hit = 1'b0;
    // stepping only on the time-period tick; a zero rate moves nothing
    if (tick) begin
      if (state_reg.cur < state_reg.desired) begin
        diff = state_reg.desired - state_reg.cur;
        // clamp at the target so it never overshoots
        state_next.cur = state_reg.cur + ((set_attack < diff) ? set_attack : diff);
      end else if (state_reg.cur > state_reg.desired) begin
        diff = state_reg.cur - state_reg.desired;
        state_next.cur = state_reg.cur - ((state_reg.cur_dec < diff) ? state_reg.cur_dec : diff);
      end
      if (state_reg.remaining != 16'h0000) begin
        state_next.remaining = state_reg.remaining - 16'h0001;
      end
    end
    // target reached: sustain becomes the next target, even above volume
    if (state_reg.cur == state_reg.desired) begin
      state_next.desired = state_reg.cur_sus;
    end
    // all-ones gap never fires
    gap_hit = (state_reg.phase == PH_NOTE) && (set_gap != `GAP_OFF) &&
              (state_reg.remaining == set_gap);
    if (note_start) begin
      // loudness itself is left alone so a loud tail decays into the note
      state_next.cur_dec = set_decay;
      state_next.desired = set_volume;
      state_next.cur_sus = set_sustain;
      state_next.remaining = note_len;
      state_next.phase = PH_NOTE;
    end else if (rest_hit) begin
      if (state_reg.phase != PH_REST) begin
        state_next.cur_dec = set_release;
        state_next.desired = 16'h0000;
        state_next.cur_sus = 16'h0000;
      end
      state_next.phase = PH_REST;
    end else if (gap_hit) begin
      state_next.cur_dec = set_release;
      state_next.desired = 16'h0000;
      state_next.cur_sus = 16'h0000;
      state_next.phase = PH_RELEASE;
    end
    if (!aresetn) begin
      state_next = '0;
    end
  end

  always_ff @(posedge aclk) begin
    state_reg <= state_next;
  end

  assign cur_loud = state_reg.cur;
  assign desired_loud = state_reg.desired;
  assign cur_sustain = state_reg.cur_sus;
  assign cur_decay = state_reg.cur_dec;
  assign remaining = state_reg.remaining;
  assign phase = state_reg.phase;
  assign card_volume = state_reg.cur[15:VOL_SHIFT];

endmodule
`default_nettype wire

// ### note_envelope_generator.sv
// note envelope generator top: settings over AXI4-Lite, per-channel engines
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "note_env_defines.svh"
module note_envelope_generator
  import note_env_pkg::*;
#(
  parameter int NUM_CH = 1,
  parameter int VOL_SHIFT = `VOL_SHIFT_1CH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic tick,
  input wire logic note_start,
  input wire logic note_rest,
  input wire logic [3:0] ev_ch,
  input wire logic [15:0] note_len,
  output logic [NUM_CH*(16-VOL_SHIFT)-1:0] card_volume,
  output logic [NUM_CH*16-1:0] loudness
);

  localparam int VOL_W = 16 - VOL_SHIFT;
  localparam logic [4:0] NUM_CH_L = 5'(NUM_CH);

  axi_s state_reg;
  axi_s state_next;
  logic wr_go;
  logic [1:0] wr_resp;
  logic [1:0] rd_resp;
  logic [3:0] wr_ch;
  logic [5:0] wr_off;
  logic [3:0] rd_ch;
  logic [5:0] rd_off;
  logic [NUM_CH-1:0] wr_hit;
  logic [31:0] chan_rd [NUM_CH];

  function automatic logic ch_ok(input logic [11:0] a);
    ch_ok = (a[11:10] == 2'b00) && ({1'b0, a[9:6]} < NUM_CH_L);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
    merge16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction

  assign wr_ch = state_reg.aw_addr[`CH_SHIFT +: `CH_IDX_W];
  assign wr_off = {state_reg.aw_addr[5:2], 2'b00};
  assign rd_ch = araddr[`CH_SHIFT +: `CH_IDX_W];
  assign rd_off = {araddr[5:2], 2'b00};
  assign wr_go = state_reg.aw_pend && state_reg.w_pend && !state_reg.bvalid;

  // status words refuse writes, so loudness has no direct path
  always_comb begin
    if (!ch_ok(state_reg.aw_addr)) begin
      wr_resp = `RESP_DECERR;
    end else if (wr_off <= `OFS_GAP) begin
      wr_resp = `RESP_OKAY;
    end else if (wr_off <= `OFS_PHASE) begin
      wr_resp = `RESP_SLVERR;
    end else begin
      wr_resp = `RESP_DECERR;
    end
  end

  always_comb begin
    if (ch_ok(araddr) && (rd_off <= `OFS_PHASE)) begin
      rd_resp = `RESP_OKAY;
    end else begin
      rd_resp = `RESP_DECERR;
    end
  end

  assign awready = !state_reg.aw_pend;
  assign wready = !state_reg.w_pend;
  assign arready = !state_reg.rvalid;

  always_comb begin
    state_next = state_reg;
    if (awvalid && !state_reg.aw_pend) begin
      state_next.aw_pend = 1'b1;
      state_next.aw_addr = awaddr;
    end
    if (wvalid && !state_reg.w_pend) begin
      state_next.w_pend = 1'b1;
      state_next.w_data = wdata;
      state_next.w_strb = wstrb;
    end
    if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      state_next.aw_pend = 1'b0;
      state_next.w_pend = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = wr_resp;
    end
    if (state_reg.rvalid && rready) begin
      state_next.rvalid = 1'b0;
    end
    if (arvalid && !state_reg.rvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = rd_resp;
      state_next.rdata = (rd_resp == `RESP_OKAY) ? chan_rd[rd_ch[3:0] % NUM_CH] : 32'h0000_0000;
    end
    if (!aresetn) begin
      state_next = '0;
    end
  end

  always_ff @(posedge aclk) begin
    state_reg <= state_next;
  end

  assign bvalid = state_reg.bvalid;
  assign bresp = state_reg.bresp;
  assign rvalid = state_reg.rvalid;
  assign rresp = state_reg.rresp;
  assign rdata = state_reg.rdata;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      settings_s cfg_reg;
      settings_s cfg_next;
      logic [15:0] cur_l;
      logic [15:0] des_l;
      logic [15:0] sus_l;
      logic [15:0] dec_l;
      logic [15:0] rem_l;
      phase_e ph;

      assign wr_hit[gi] = wr_go && (wr_resp == `RESP_OKAY) && (wr_ch == 4'(gi));

      // latest settings; the sequencer rewrites them between notes
      always_comb begin
        cfg_next = cfg_reg;
        if (wr_hit[gi]) begin
          unique case (wr_off)
            `OFS_ATTACK: cfg_next.attack = merge16(cfg_reg.attack, state_reg.w_data,
                                                   state_reg.w_strb);
            `OFS_DECAY: cfg_next.decay = merge16(cfg_reg.decay, state_reg.w_data,
                                                 state_reg.w_strb);
            `OFS_SUSTAIN: cfg_next.sustain = merge16(cfg_reg.sustain, state_reg.w_data,
                                                     state_reg.w_strb);
            `OFS_RELEASE: cfg_next.release_rate = merge16(cfg_reg.release_rate,
                                                          state_reg.w_data, state_reg.w_strb);
            `OFS_VOLUME: cfg_next.volume = merge16(cfg_reg.volume, state_reg.w_data,
                                                   state_reg.w_strb);
            `OFS_GAP: cfg_next.gap = merge16(cfg_reg.gap, state_reg.w_data, state_reg.w_strb);
            default: cfg_next = cfg_reg;
          endcase
        end
        if (!aresetn) begin
          cfg_next = {`RST_ATTACK, `RST_DECAY, `RST_SUSTAIN, `RST_RELEASE, `RST_VOLUME,
                      `RST_GAP};
        end
      end

      always_ff @(posedge aclk) begin
        cfg_reg <= cfg_next;
      end

      env_channel #(
        .VOL_SHIFT(VOL_SHIFT)
      ) u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .note_start(note_start && (ev_ch == 4'(gi))),
        .rest_hit(note_rest && (ev_ch == 4'(gi))),
        .note_len(note_len),
        .set_attack(cfg_reg.attack),
        .set_decay(cfg_reg.decay),
        .set_sustain(cfg_reg.sustain),
        .set_release(cfg_reg.release_rate),
        .set_volume(cfg_reg.volume),
        .set_gap(cfg_reg.gap),
        .cur_loud(cur_l),
        .desired_loud(des_l),
        .cur_sustain(sus_l),
        .cur_decay(dec_l),
        .remaining(rem_l),
        .phase(ph),
        .card_volume(card_volume[gi*VOL_W +: VOL_W])
      );

      assign loudness[gi*16 +: 16] = cur_l;

      always_comb begin
        unique case (rd_off)
          `OFS_ATTACK: chan_rd[gi] = {16'h0000, cfg_reg.attack};
          `OFS_DECAY: chan_rd[gi] = {16'h0000, cfg_reg.decay};
          `OFS_SUSTAIN: chan_rd[gi] = {16'h0000, cfg_reg.sustain};
          `OFS_RELEASE: chan_rd[gi] = {16'h0000, cfg_reg.release_rate};
          `OFS_VOLUME: chan_rd[gi] = {16'h0000, cfg_reg.volume};
          `OFS_GAP: chan_rd[gi] = {16'h0000, cfg_reg.gap};
          `OFS_LOUD: chan_rd[gi] = {des_l, cur_l};
          `OFS_RATE: chan_rd[gi] = {sus_l, dec_l};
          `OFS_PHASE: chan_rd[gi] = {14'h0000, ph, rem_l};
          default: chan_rd[gi] = 32'h0000_0000;
        endcase
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### env_properties.sv
// concurrent checks on the envelope generator ports
`timescale 1ns/1ps
`default_nettype none
module env_properties #(
  parameter int NUM_CH = 1,
  parameter int VOL_SHIFT = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic tick,
  input wire logic note_start,
  input wire logic note_rest,
  input wire logic [3:0] ev_ch,
  input wire logic [NUM_CH*16-1:0] loudness,
  input wire logic [NUM_CH*(16-VOL_SHIFT)-1:0] card_volume
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_vol_map: assert property (card_volume[15-VOL_SHIFT:0] == loudness[15:VOL_SHIFT])
    else $error("card volume differs from loudness");
  a_tick_only: assert property (!tick |=> $stable(loudness))
    else $error("loudness moved without tick");
  a_reset_clr: assert property (disable iff (1'b0) !aresetn |=> loudness == '0 && !bvalid)
    else $error("reset left state");
  a_rest_fall: assert property ((note_rest && !note_start && !tick && ev_ch == 4'h0)
    ##1 (!note_start) [*2] |-> loudness[15:0] <= $past(loudness[15:0]))
    else $error("loudness rose after rest");
  a_b_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  a_ar_ready: assert property (arready == !rvalid)
    else $error("read ready wrong");
  a_rd_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  // taken at one edge, bvalid set at the next, seen one edge later
  a_wr_resp: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  cover property (note_start ##[1:30] tick);
  cover property (note_rest ##[1:20] note_rest);
  cover property (bvalid && bready);
endmodule
`default_nettype wire

// ### note_sequencer.sv
// sequencer model: ticks, notes and rests for the envelope block
`timescale 1ns/1ps
`default_nettype none
module note_sequencer (
  input wire logic aclk,
  output logic tick,
  output logic note_start,
  output logic note_rest,
  output logic [3:0] ev_ch,
  output logic [15:0] note_len
);
  initial {tick, note_start, note_rest, ev_ch, note_len} = '0;
  // one pulse, then a quiet cycle; idle fields show the inverse
  task automatic ev(input logic tk, nt, rs, input logic [3:0] ch, input logic [15:0] ln);
    tick <= tk;
    note_start <= nt;
    note_rest <= rs;
    ev_ch <= ch;
    note_len <= ln;
    @(posedge aclk);
    {tick, note_start, note_rest} <= 3'b000;
    ev_ch <= ~ch;
    note_len <= ~ln;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the note envelope generator
`timescale 1ns/1ps
`default_nettype none
`include "note_env_defines.svh"
module tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tick, note_start, note_rest;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, ev_ch, card_volume;
  logic [1:0] bresp, rresp, r;
  logic [15:0] note_len, loudness, cur, des, sus, dec, rem, len;
  logic [15:0] s [6];
  logic [31:0] rv [8];
  int error_cnt, total_checks, ph, i, k;
  note_envelope_generator dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .tick, .note_start, .note_rest, .ev_ch, .note_len, .card_volume,
    .loudness);
  note_sequencer seq (.aclk, .tick, .note_start, .note_rest, .ev_ch, .note_len);
  always #10 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    results();
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    int n;
    logic aw_ok, w_ok, b_ok;
    awaddr <= a;
    wdata <= {16'h0, v};
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'b111;
    for (n = 0; n < 50; n++) begin
      // sample the handshake while settled, act on the next edge
      @(negedge aclk);
      aw_ok = awready;
      w_ok = wready;
      b_ok = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) break;
    end
    bready <= 1'b0;
    if (n == 50) tmo();
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    logic ar_ok, r_ok;
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ar_ok = arready;
      r_ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) break;
    end
    rready <= 1'b0;
    if (n == 50) tmo();
    @(posedge aclk);
  endtask
  task automatic reset_check();
    for (i = 0; i < 8; i++) begin
      rd(12'(i * 4));
      chk(d, rv[i]);
    end
    rd({6'h0, `OFS_PHASE});
    chk(d, 32'h0);
  endtask
  function automatic logic [15:0] step(logic [15:0] c, t, u, dn);
    if (c < t) return (t - c > u) ? c + u : t;
    if (c > t) return (c - t > dn) ? c - dn : t;
    return c;
  endfunction
  function automatic void rel();
    dec = s[3];
    des = 16'h0;
    sus = 16'h0;
    ph = 3;
  endfunction
  task automatic go(input logic tk, nt, rs, input logic [3:0] ch, input logic [15:0] ln);
    seq.ev(tk, nt, rs, ch, ln);
    if (tk) begin
      cur = step(cur, des, s[0], dec);
      if (rem != 16'h0) rem = rem - 16'h1;
    end
    if (nt && ch == 4'h0) begin
      des = s[4];
      dec = s[1];
      sus = s[2];
      rem = ln;
      ph = 1;
    end else if (rs && ch == 4'h0 && ph != 2) begin
      rel();
      ph = 2;
    end
    if (cur == des) des = sus;
    if (ph == 1 && s[5] != `GAP_OFF && rem == s[5]) rel();
    chk({16'h0, loudness}, {16'h0, cur});
    chk({28'h0, card_volume}, {28'h0, cur[15:12]});
  endtask
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {cur, des, sus, dec, rem} = '0;
    s = '{16'h2000, 16'h0, 16'h0, 16'h0, 16'h0, 16'hFFFF};
    rv = '{32'h2000, 0, 0, 0, 0, 32'hFFFF, 0, 0};
    void'($urandom(46362));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reset_check();
    $display("reset test done");
    wr({6'h0, `OFS_LOUD}, 16'h1234);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    wr(12'h024, 16'h1);
    chk({30'h0, r}, {30'h0, `RESP_DECERR});
    rd({6'h0, `OFS_LOUD});
    chk(d, 32'h0);
    rd(12'h400);
    chk({30'h0, r}, {30'h0, `RESP_DECERR});
    $display("access test done");
    for (k = 0; k < 6; k++) begin
      len = 16'($urandom_range(10, 40));
      s[0] = k == 0 ? 16'h0 : k == 1 ? 16'h1 : 16'($urandom);
      s[1] = 16'($urandom_range(1, 4000));
      s[4] = 16'($urandom);
      s[2] = k == 3 ? s[4] : 16'($urandom);
      s[3] = 16'($urandom_range(1, 8000));
      s[5] = k == 2 ? `GAP_OFF : 16'($urandom_range(0, len));
      // settings land before the note starts
      for (i = 0; i < 6; i++) wr(12'(i * 4), s[i]);
      go(1'b0, 1'b1, 1'b0, 4'h1, len);
      go(1'b0, 1'b1, 1'b0, 4'h0, len);
      rd({6'h0, `OFS_RATE});
      chk(d, {sus, dec});
      rd({6'h0, `OFS_PHASE});
      chk(d, {14'h0, ph[1:0], rem});
      repeat (len + 4) go(1'b1, 1'b0, 1'b0, 4'h0, 16'h0);
      go(1'b0, 1'b0, 1'b1, 4'h0, 16'h0);
      s[3] = 16'($urandom_range(1, 8000));
      wr({6'h0, `OFS_RELEASE}, s[3]);
      go(1'b0, 1'b0, 1'b1, 4'h0, 16'h0);
      rd({6'h0, `OFS_RATE});
      chk(d, {sus, dec});
      rd({6'h0, `OFS_PHASE});
      chk(d, {14'h0, ph[1:0], rem});
      repeat (6) go(1'b1, 1'b0, 1'b0, 4'h0, 16'h0);
      rd({6'h0, `OFS_LOUD});
      chk(d, {des, cur});
      $display("round %0d done", k);
    end
    // reset in mid-run must clear a live envelope
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    {cur, des, sus, dec, rem} = '0;
    ph = 0;
    @(posedge aclk);
    reset_check();
    go(1'b1, 1'b0, 1'b0, 4'h0, 16'h0);
    $display("second reset test done");
    results();
  end
endmodule
bind note_envelope_generator env_properties #(.NUM_CH(NUM_CH), .VOL_SHIFT(VOL_SHIFT)) props (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
  .arready, .rvalid, .rready, .rdata, .tick, .note_start, .note_rest, .ev_ch, .loudness,
  .card_volume);
`default_nettype wire
